// ==== hdl/psq_defines.vh ====
// Register offsets, field positions, codes and timing for the power state sequencer
`ifndef PSQ_DEFINES_VH
`define PSQ_DEFINES_VH

// Register offsets
`define PSQ_REG_RET_HOLD 8'h3D
`define PSQ_REG_FAULT_MAP 8'h44
`define PSQ_REG_GPIO4_MASK 8'h4F
`define PSQ_REG_GPIO_FLAGS 8'h64
`define PSQ_REG_START_FLAGS 8'h65
`define PSQ_REG_TEST_FLAGS 8'h66
`define PSQ_REG_TRIGGERS 8'h85
`define PSQ_REG_SLEEP 8'h86
`define PSQ_REG_STATE 8'h8F
`define PSQ_REG_TIMER_RUN 8'hC2
`define PSQ_REG_RTC_CFG 8'hC3
`define PSQ_REG_TIMER_STAT 8'hC4
`define PSQ_REG_TIMER_INT 8'hC5

// Field positions
`define PSQ_BIT_RET_HOLD 1
`define PSQ_FLD_ROUTE_HI 3
`define PSQ_FLD_ROUTE_LO 2
`define PSQ_BIT_GPIO4 3
`define PSQ_BIT_ENABLE_FLAG 1
`define PSQ_BIT_PASS_FLAG 0
`define PSQ_BIT_FAULT_FLAG 1
`define PSQ_BIT_STANDBY_TRIG 0
`define PSQ_BIT_RET_TRIG 7
`define PSQ_BIT_SLEEP_A 0
`define PSQ_BIT_SLEEP_B 1
`define PSQ_BIT_TIMER_RUN 0
`define PSQ_BIT_CRYSTAL 0
`define PSQ_BIT_DEEP_SEL 3
`define PSQ_FLD_DEST_HI 6
`define PSQ_FLD_DEST_LO 5
`define PSQ_BIT_TIMER_FLAG 5
`define PSQ_BIT_TIMER_IE 2

// Codes and reset values
`define PSQ_ROUTE_MCU_ERR 2'h2
`define PSQ_DEST_ACTIVE 2'h3
`define PSQ_BYTE_ZERO 8'h00
`define PSQ_SLEEP_RESET 8'h00
`define PSQ_GPIO4_MASK_RESET 8'h08
`define PSQ_RTC_CFG_RESET 8'h60
`define PSQ_TARGET_ADDR 7'h48

// Timing
`define PSQ_CLK_HZ 64'd200000000
`define PSQ_TIMER_PERIOD_S 64'd60
`define PSQ_TIMER_W 36

`endif

// ==== hdl/psq_power_sequencer.v ====
// Power state sequencer with I2C target register port
`include "psq_defines.vh"

// Notes on behaviour
// RULE_01: Host merges masked bits by read-modify-write
// RULE_02: Host routes rail fault to code 10b
// RULE_03: Power-up sets pass and enable flags
// RULE_04: Host inspects, sets sleep bits, then clears
// RULE_05: Enable rising edge moves chips to ACTIVE
// RULE_06: Interrupt pin driven high on pending events
// RULE_07: Enable flag blocks lower priority triggers
// RULE_08: Sleep bits and trigger select target state
// RULE_09: Host sets sleep bits before clearing enable
// RULE_10: Host clears pass flag and on-request sources
// RULE_11: Host configures wake path before retention
// RULE_12: Host sets retention trigger before retention
// RULE_13: Host drives retention hold around retention
// RULE_14: GPIO4 wake flag write-one-clear, mask unmask
// RULE_15: Clearing both sleep bits enters retention
// RULE_16: Host resets sleep bits and wake flag
// RULE_17: Host enables crystal, period, then starts timer
// RULE_18: Host disables timer interrupt and clears flag
// RULE_19: Standby from ACTIVE or RETENTION, select clear
// RULE_20: Standby returns only to ACTIVE, rails off
// RULE_21: Enable fall or trigger enters standby
// RULE_22: Retention trigger bit holds until rewritten
// RULE_23: Host addresses chip by its target address
module psq_power_sequencer #(
    parameter [6:0] TARGET_ADDR = `PSQ_TARGET_ADDR,
    parameter [63:0] TIMER_CYCLES = `PSQ_TIMER_PERIOD_S * `PSQ_CLK_HZ
)(
    input wire sys_clk_i,
    input wire reset_n_i,
    input wire scl_i,
    input wire sda_i,
    output reg sda_o,
    output reg sda_oe_o,
    input wire enable_pin_i,
    input wire gpio4_pin_i,
    input wire rail_fault_i,
    output reg interrupt_out_pin_o,
    output reg proc_rails_on_o,
    output reg ddr_rails_on_o,
    output reg retention_hold_gpio_o,
    output reg [2:0] power_state_o
);
    localparam [2:0] ST_OFF = 3'h0;
    localparam [2:0] ST_ACTIVE = 3'h1;
    localparam [2:0] ST_RET = 3'h2;
    localparam [2:0] ST_DDR_RET = 3'h3;
    localparam [2:0] ST_STANDBY = 3'h4;
    localparam [2:0] ST_DEEP = 3'h5;

    localparam [1:0] I_IDLE = 2'h0;
    localparam [1:0] I_ADDR = 2'h1;
    localparam [1:0] I_WRITE = 2'h2;
    localparam [1:0] I_READ = 2'h3;

    // Three-stage synchronisers: a change counts when stages two and three agree
    reg [2:0] scl_s_r, sda_s_r, en_s_r, g4_s_r, flt_s_r;
    reg scl_f_r, sda_f_r, en_f_r, g4_f_r, flt_f_r;

    always @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            scl_s_r <= 3'h7;
            sda_s_r <= 3'h7;
            en_s_r <= 3'h0;
            g4_s_r <= 3'h7;
            flt_s_r <= 3'h0;
            scl_f_r <= 1'h1;
            sda_f_r <= 1'h1;
            en_f_r <= 1'h0;
            g4_f_r <= 1'h1;
            flt_f_r <= 1'h0;
        end
        else
        begin
            scl_s_r <= {scl_s_r[1:0], scl_i};
            sda_s_r <= {sda_s_r[1:0], sda_i};
            en_s_r <= {en_s_r[1:0], enable_pin_i};
            g4_s_r <= {g4_s_r[1:0], gpio4_pin_i};
            flt_s_r <= {flt_s_r[1:0], rail_fault_i};
            if (scl_s_r[1] == scl_s_r[2])
                scl_f_r <= scl_s_r[2];
            if (sda_s_r[1] == sda_s_r[2])
                sda_f_r <= sda_s_r[2];
            if (en_s_r[1] == en_s_r[2])
                en_f_r <= en_s_r[2];
            if (g4_s_r[1] == g4_s_r[2])
                g4_f_r <= g4_s_r[2];
            if (flt_s_r[1] == flt_s_r[2])
                flt_f_r <= flt_s_r[2];
        end
    end

    // Previous filtered levels for edge detection
    reg scl_p_r, sda_p_r, en_p_r, g4_p_r, flt_p_r;
    wire scl_rise = scl_f_r & ~scl_p_r;
    wire scl_fall = ~scl_f_r & scl_p_r;
    wire i2c_start = scl_f_r & scl_p_r & sda_p_r & ~sda_f_r;
    wire i2c_stop = scl_f_r & scl_p_r & ~sda_p_r & sda_f_r;
    wire en_rise = en_f_r & ~en_p_r;
    wire en_fall = ~en_f_r & en_p_r;
    wire g4_fall = ~g4_f_r & g4_p_r;
    wire flt_rise = flt_f_r & ~flt_p_r;

    // Register file
    reg [7:0] ret_hold_r, fault_map_r, g4_mask_r, gpio_flags_r, start_flags_r;
    reg [7:0] test_flags_r, triggers_r, sleep_r, timer_run_r, rtc_cfg_r;
    reg [7:0] timer_stat_r, timer_int_r;
    reg [2:0] state_r;

    function [7:0] reg_read;
        input [7:0] addr;
        begin
            case (addr)
                `PSQ_REG_RET_HOLD: reg_read = ret_hold_r;
                `PSQ_REG_FAULT_MAP: reg_read = fault_map_r;
                `PSQ_REG_GPIO4_MASK: reg_read = g4_mask_r;
                `PSQ_REG_GPIO_FLAGS: reg_read = gpio_flags_r;
                `PSQ_REG_START_FLAGS: reg_read = start_flags_r;
                `PSQ_REG_TEST_FLAGS: reg_read = test_flags_r;
                `PSQ_REG_TRIGGERS: reg_read = triggers_r;
                `PSQ_REG_SLEEP: reg_read = sleep_r;
                `PSQ_REG_STATE: reg_read = {5'h00, state_r};
                `PSQ_REG_TIMER_RUN: reg_read = timer_run_r;
                `PSQ_REG_RTC_CFG: reg_read = rtc_cfg_r;
                `PSQ_REG_TIMER_STAT: reg_read = timer_stat_r;
                `PSQ_REG_TIMER_INT: reg_read = timer_int_r;
                default: reg_read = `PSQ_BYTE_ZERO;
            endcase
        end
    endfunction

    // I2C target engine
    reg [1:0] i_state_r;
    reg [3:0] bit_cnt_r;
    reg [7:0] shift_r, tx_r, ptr_r;
    reg first_r, ack_r;
    reg wr_stb_r;
    reg [7:0] wr_addr_r, wr_data_r;
    wire [7:0] rx_byte = {shift_r[6:0], sda_f_r};

    always @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            scl_p_r <= 1'h1;
            sda_p_r <= 1'h1;
            i_state_r <= I_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            tx_r <= 8'h00;
            ptr_r <= 8'h00;
            first_r <= 1'h0;
            ack_r <= 1'h0;
            wr_stb_r <= 1'h0;
            wr_addr_r <= 8'h00;
            wr_data_r <= 8'h00;
            sda_o <= 1'h0;
            sda_oe_o <= 1'h0;
        end
        else
        begin
            scl_p_r <= scl_f_r;
            sda_p_r <= sda_f_r;
            wr_stb_r <= 1'h0;
            sda_o <= 1'h0;
            if (i2c_start)
            begin
                i_state_r <= I_ADDR;
                bit_cnt_r <= 4'h0;
                sda_oe_o <= 1'h0;
            end
            else if (i2c_stop)
            begin
                i_state_r <= I_IDLE;
                sda_oe_o <= 1'h0;
            end
            else if (i_state_r != I_IDLE && scl_rise)
            begin
                if (bit_cnt_r == 4'h8)
                begin
                    bit_cnt_r <= 4'h0;
                    if (!ack_r)
                    begin
                        if (sda_f_r)
                            i_state_r <= I_IDLE;
                        else
                        begin
                            ptr_r <= ptr_r + 8'h01;
                            tx_r <= reg_read(ptr_r + 8'h01);
                        end
                    end
                end
                else
                begin
                    shift_r <= rx_byte;
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                    ack_r <= (i_state_r != I_READ);
                    if (bit_cnt_r == 4'h7)
                    begin
                        if (i_state_r == I_ADDR)
                        begin
                            if (rx_byte[7:1] == TARGET_ADDR)
                            begin
                                i_state_r <= rx_byte[0] ? I_READ : I_WRITE;
                                tx_r <= reg_read(ptr_r);
                                first_r <= 1'h1;
                            end
                            else
                            begin
                                i_state_r <= I_IDLE;
                                ack_r <= 1'h0;
                            end
                        end
                        else if (i_state_r == I_WRITE)
                        begin
                            first_r <= 1'h0;
                            if (first_r)
                                ptr_r <= rx_byte;
                            else
                            begin
                                wr_stb_r <= 1'h1;
                                wr_addr_r <= ptr_r;
                                wr_data_r <= rx_byte;
                                ptr_r <= ptr_r + 8'h01;
                            end
                        end
                    end
                end
            end
            else if (i_state_r != I_IDLE && scl_fall)
            begin
                if (bit_cnt_r == 4'h8)
                    sda_oe_o <= ack_r;
                else if (i_state_r == I_READ)
                    sda_oe_o <= ~tx_r[3'h7 - bit_cnt_r[2:0]];
                else
                    sda_oe_o <= 1'h0;
            end
        end
    end

    // Write strobes per register
    wire wr_gpio = wr_stb_r && wr_addr_r == `PSQ_REG_GPIO_FLAGS;
    wire wr_start = wr_stb_r && wr_addr_r == `PSQ_REG_START_FLAGS;
    wire wr_test = wr_stb_r && wr_addr_r == `PSQ_REG_TEST_FLAGS;
    wire wr_trig = wr_stb_r && wr_addr_r == `PSQ_REG_TRIGGERS;
    wire wr_tstat = wr_stb_r && wr_addr_r == `PSQ_REG_TIMER_STAT;

    // Wake timer, minute period
    reg [`PSQ_TIMER_W-1:0] timer_cnt_r;
    reg timer_exp_r;
    wire timer_on = timer_run_r[`PSQ_BIT_TIMER_RUN] & rtc_cfg_r[`PSQ_BIT_CRYSTAL];

    // State triggers seen by the sequencer
    wire enable_blk = start_flags_r[`PSQ_BIT_ENABLE_FLAG];
    wire g4_wake = g4_fall & ~g4_mask_r[`PSQ_BIT_GPIO4];
    wire timer_wake = timer_exp_r & timer_int_r[`PSQ_BIT_TIMER_IE];
    wire sb_req = en_fall | triggers_r[`PSQ_BIT_STANDBY_TRIG];
    wire sleep_ab = sleep_r[`PSQ_BIT_SLEEP_A] & sleep_r[`PSQ_BIT_SLEEP_B];
    wire on_req = en_rise;
    reg [2:0] state_nxt;
    reg set_on_flags;

    always @*
    begin
        state_nxt = state_r;
        set_on_flags = 1'h0;
        case (state_r)
            ST_OFF:
                if (on_req) // see RULE_05
                begin
                    state_nxt = ST_ACTIVE;
                    set_on_flags = 1'h1; // see RULE_03
                end
            ST_ACTIVE:
                if (enable_blk)
                    state_nxt = ST_ACTIVE; // see RULE_07
                else if (sb_req)
                    state_nxt = ST_STANDBY; // see RULE_19 see RULE_21
                else if (!sleep_r[`PSQ_BIT_SLEEP_B])
                    state_nxt = triggers_r[`PSQ_BIT_RET_TRIG] ? ST_DDR_RET : ST_RET; // see RULE_08 see RULE_15 see RULE_22
            ST_RET, ST_DDR_RET:
                if (sb_req)
                    state_nxt = ST_STANDBY; // see RULE_19
                else if (g4_wake || timer_wake || sleep_ab)
                    state_nxt = ST_ACTIVE; // see RULE_08 see RULE_14
            ST_STANDBY:
                if (on_req || g4_wake || timer_wake)
                begin
                    state_nxt = ST_ACTIVE; // see RULE_20 see RULE_21
                    set_on_flags = on_req;
                end
                else if (rtc_cfg_r[`PSQ_BIT_DEEP_SEL])
                    state_nxt = ST_DEEP; // see RULE_19
            ST_DEEP:
                if (on_req && rtc_cfg_r[`PSQ_FLD_DEST_HI:`PSQ_FLD_DEST_LO] == `PSQ_DEST_ACTIVE)
                begin
                    state_nxt = ST_ACTIVE; // see RULE_21
                    set_on_flags = 1'h1;
                end
            default:
                state_nxt = ST_OFF;
        endcase
    end

    // Hardware sets win over software clears on every flag
    always @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            en_p_r <= 1'h0;
            g4_p_r <= 1'h1;
            flt_p_r <= 1'h0;
            state_r <= ST_OFF;
            ret_hold_r <= `PSQ_BYTE_ZERO;
            fault_map_r <= `PSQ_BYTE_ZERO;
            g4_mask_r <= `PSQ_GPIO4_MASK_RESET;
            gpio_flags_r <= `PSQ_BYTE_ZERO;
            start_flags_r <= `PSQ_BYTE_ZERO;
            test_flags_r <= `PSQ_BYTE_ZERO;
            triggers_r <= `PSQ_BYTE_ZERO;
            sleep_r <= `PSQ_SLEEP_RESET;
            timer_run_r <= `PSQ_BYTE_ZERO;
            rtc_cfg_r <= `PSQ_RTC_CFG_RESET;
            timer_stat_r <= `PSQ_BYTE_ZERO;
            timer_int_r <= `PSQ_BYTE_ZERO;
            timer_cnt_r <= {`PSQ_TIMER_W{1'b0}};
            timer_exp_r <= 1'h0;
        end
        else
        begin
            en_p_r <= en_f_r;
            g4_p_r <= g4_f_r;
            flt_p_r <= flt_f_r;
            state_r <= state_nxt;
            timer_exp_r <= 1'h0;
            if (!timer_on)
                timer_cnt_r <= {`PSQ_TIMER_W{1'b0}};
            else if (timer_cnt_r == TIMER_CYCLES[`PSQ_TIMER_W-1:0] - 1'b1)
            begin
                timer_cnt_r <= {`PSQ_TIMER_W{1'b0}};
                timer_exp_r <= 1'h1;
            end
            else
                timer_cnt_r <= timer_cnt_r + 1'b1;
            if (wr_stb_r)
            begin
                case (wr_addr_r)
                    `PSQ_REG_RET_HOLD: ret_hold_r <= wr_data_r;
                    `PSQ_REG_FAULT_MAP: fault_map_r <= wr_data_r;
                    `PSQ_REG_GPIO4_MASK: g4_mask_r <= wr_data_r;
                    `PSQ_REG_SLEEP: sleep_r <= wr_data_r;
                    `PSQ_REG_TIMER_RUN: timer_run_r <= wr_data_r;
                    `PSQ_REG_RTC_CFG: rtc_cfg_r <= wr_data_r;
                    `PSQ_REG_TIMER_INT: timer_int_r <= wr_data_r;
                    default: ;
                endcase
            end
            gpio_flags_r <= (gpio_flags_r & ~(wr_gpio ? wr_data_r : 8'h00))
                | ({7'h00, g4_fall} << `PSQ_BIT_GPIO4); // see RULE_14
            start_flags_r <= (start_flags_r & ~(wr_start ? wr_data_r : 8'h00))
                | ({7'h00, set_on_flags} << `PSQ_BIT_ENABLE_FLAG); // see RULE_03
            test_flags_r <= (test_flags_r & ~(wr_test ? wr_data_r : 8'h00))
                | ({7'h00, set_on_flags} << `PSQ_BIT_PASS_FLAG)
                | ({7'h00, flt_rise && fault_map_r[`PSQ_FLD_ROUTE_HI:`PSQ_FLD_ROUTE_LO]
                    == `PSQ_ROUTE_MCU_ERR} << `PSQ_BIT_FAULT_FLAG);
            // Standby trigger self-clears once acted upon; other bits hold
            if (wr_trig)
                triggers_r <= wr_data_r; // see RULE_22
            else if (state_nxt == ST_STANDBY)
                triggers_r[`PSQ_BIT_STANDBY_TRIG] <= 1'h0;
            // Timer flag cleared by writing zero to it
            timer_stat_r[`PSQ_BIT_TIMER_FLAG] <= timer_wake
                | (timer_stat_r[`PSQ_BIT_TIMER_FLAG]
                & ~(wr_tstat & ~wr_data_r[`PSQ_BIT_TIMER_FLAG]));
        end
    end

    // Pin outputs
    always @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            interrupt_out_pin_o <= 1'h0;
            proc_rails_on_o <= 1'h0;
            ddr_rails_on_o <= 1'h0;
            retention_hold_gpio_o <= 1'h0;
            power_state_o <= ST_OFF;
        end
        else
        begin
            interrupt_out_pin_o <= |{gpio_flags_r, start_flags_r, test_flags_r,
                timer_stat_r[`PSQ_BIT_TIMER_FLAG]}; // see RULE_06
            proc_rails_on_o <= (state_r == ST_ACTIVE); // see RULE_20
            ddr_rails_on_o <= (state_r == ST_ACTIVE) || (state_r == ST_DDR_RET);
            retention_hold_gpio_o <= ret_hold_r[`PSQ_BIT_RET_HOLD];
            power_state_o <= state_r;
        end
    end
endmodule

// ==== sim/psq_power_sequencer_monitor.sv ====
// Concurrent checks on the power state sequencer ports
module psq_power_sequencer_monitor (
    input wire sys_clk_i,
    input wire reset_n_i,
    input wire scl_i,
    input wire sda_i,
    input wire sda_o,
    input wire sda_oe_o,
    input wire enable_pin_i,
    input wire gpio4_pin_i,
    input wire rail_fault_i,
    input wire interrupt_out_pin_o,
    input wire proc_rails_on_o,
    input wire ddr_rails_on_o,
    input wire retention_hold_gpio_o,
    input wire [2:0] power_state_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!reset_n_i);
    sequence s_power_up;
        power_state_o == 3'h0 ##1 power_state_o == 3'h1;
    endsequence
    sequence s_left_standby;
        $past(power_state_o) == 3'h4 && power_state_o != 3'h4;
    endsequence
    proc_rails_track_a: assert property (proc_rails_on_o == (power_state_o == 3'h1))
        else $error("processor rails disagree with state");
    ddr_rails_track_a: assert property (
        ddr_rails_on_o == (power_state_o inside {3'h1, 3'h3}))
        else $error("memory rails disagree with state");
    power_up_irq_a: assert property (s_power_up |-> ##[0:3] interrupt_out_pin_o)
        else $error("interrupt pin not raised after power up");
    enable_flag_hold_a: assert property (s_power_up |=> (power_state_o == 3'h1) [*8])
        else $error("left active while enable flag pending");
    enable_wake_a: assert property (
        $rose(enable_pin_i) && power_state_o inside {3'h0, 3'h4, 3'h5}
        |-> ##[1:12] power_state_o == 3'h1)
        else $error("enable rise did not reach active");
    standby_exit_a: assert property (s_left_standby |-> power_state_o inside {3'h1, 3'h5})
        else $error("standby left to a wrong state");
    retention_entry_a: assert property (
        $changed(power_state_o) && power_state_o inside {3'h2, 3'h3} |-> $past(power_state_o) == 3'h1)
        else $error("retention entered from a wrong state");
    deep_entry_a: assert property (
        $changed(power_state_o) && power_state_o == 3'h5 |-> $past(power_state_o) == 3'h4)
        else $error("deep standby entered from a wrong state");
    standby_req_a: assert property (
        $fell(enable_pin_i) && power_state_o == 3'h1 && !interrupt_out_pin_o
        |-> ##[1:12] power_state_o inside {3'h4, 3'h5})
        else $error("enable fall did not start standby");
endmodule

bind psq_power_sequencer psq_power_sequencer_monitor u_psq_power_sequencer_monitor (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .enable_pin_i(enable_pin_i),
    .gpio4_pin_i(gpio4_pin_i), .rail_fault_i(rail_fault_i),
    .interrupt_out_pin_o(interrupt_out_pin_o), .proc_rails_on_o(proc_rails_on_o),
    .ddr_rails_on_o(ddr_rails_on_o), .retention_hold_gpio_o(retention_hold_gpio_o),
    .power_state_o(power_state_o)
);

// ==== sim/psq_i2c_host_model.sv ====
// Host controller model driving the two-wire register link
module psq_i2c_host_model (
    input wire sys_clk_i,
    input wire sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int Q = 6;
    logic scl_r = 1'b1;
    logic low_r = 1'b0;
    logic ack;
    assign scl_o = scl_r;
    assign sda_low_o = low_r;
    task automatic hold();
        repeat (Q) @(posedge sys_clk_i);
    endtask
    task automatic bit_io(input logic b, output logic r);
        low_r <= !b;
        hold();
        scl_r <= 1'b1;
        hold();
        r = sda_i;
        scl_r <= 1'b0;
        hold();
    endtask
    task automatic start();
        low_r <= 1'b0;
        hold();
        scl_r <= 1'b1;
        hold();
        low_r <= 1'b1;
        hold();
        scl_r <= 1'b0;
        hold();
    endtask
    task automatic stop();
        low_r <= 1'b1;
        hold();
        scl_r <= 1'b1;
        hold();
        low_r <= 1'b0;
        hold();
    endtask
    // Last high releases the acknowledge slot
    task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(last, r);
        ack = !r;
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] r, output logic [7:0] d,
                      output logic ok);
        logic [7:0] q;
        start();
        xfer({a, 1'b0}, 1'b1, q);
        ok = ack;
        xfer(r, 1'b1, q);
        ok &= ack;
        start();
        xfer({a, 1'b1}, 1'b1, q);
        ok &= ack;
        xfer(8'hFF, 1'b1, d);
        stop();
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] r, input logic [7:0] v,
                      output logic ok);
        logic [7:0] q;
        start();
        xfer({a, 1'b0}, 1'b1, q);
        ok = ack;
        xfer(r, 1'b1, q);
        ok &= ack;
        xfer(v, 1'b1, q);
        ok &= ack;
        stop();
    endtask
    task automatic wrm(input logic [6:0] a, input logic [7:0] r, input logic [7:0] v,
                       input logic [7:0] m);
        logic [7:0] old;
        logic ok;
        old = 8'h00;
        if (m != 8'h00)
            rd(a, r, old, ok);
        wr(a, r, (old & m) | (v & ~m), ok);
    endtask
endmodule

// ==== sim/tb_pmic_power_state_host_sequencer.sv ====
// Self-checking bench for the power state sequencer
module tb_pmic_power_state_host_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [6:0] DEV = 7'h48;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic enable_pin = 1'b0;
    logic gpio4_pin = 1'b1;
    logic rail_fault = 1'b0;
    logic [31:0] lfsr = 32'hA0E26252;
    logic [7:0] rdv;
    logic ok;
    int num_errors = 0;
    int check_count = 0;
    wire scl, host_low, sda_oe, sda_drv, irq, proc_on, ddr_on, hold_gpio;
    wire [2:0] state;
    wire sda_w = !(host_low | (sda_oe & !sda_drv));
    always #2.5 sys_clk = ~sys_clk;
    psq_power_sequencer #(.TIMER_CYCLES(64'h9C4)) u_psq_power_sequencer (
        .sys_clk_i(sys_clk), .reset_n_i(reset_n), .scl_i(scl), .sda_i(sda_w),
        .sda_o(sda_drv), .sda_oe_o(sda_oe), .enable_pin_i(enable_pin),
        .gpio4_pin_i(gpio4_pin), .rail_fault_i(rail_fault), .interrupt_out_pin_o(irq),
        .proc_rails_on_o(proc_on), .ddr_rails_on_o(ddr_on),
        .retention_hold_gpio_o(hold_gpio), .power_state_o(state)
    );
    psq_i2c_host_model u_host (
        .sys_clk_i(sys_clk), .sda_i(sda_w), .scl_o(scl), .sda_low_o(host_low)
    );
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic [7:0] exp_route(input logic [1:0] r);
        return {4'h0, r, 2'h0};
    endfunction
    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        chk_byte(what, {7'h00, exp}, {7'h00, got});
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        u_host.rd(DEV, a, rdv, ok);
        chk_bit("read ack", 1'b1, ok);
        chk_byte("register", exp, rdv);
    endtask
    task automatic w(input logic [7:0] a, input logic [7:0] v, input logic [7:0] m);
        u_host.wrm(DEV, a, v, m);
    endtask
    task automatic wst(input logic [2:0] s);
        for (int i = 0; i < 3000 && state !== s; i++)
            @(posedge sys_clk);
        chk_byte("power state", {5'h00, s}, {5'h00, state});
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (90000) @(posedge sys_clk);
        num_errors++;
        stop_test();
    end
    initial
    begin
        repeat (5) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (6) @(posedge sys_clk);
        chk_byte("state after reset", 8'h00, {5'h00, state});
        rchk(8'h4F, 8'h08);
        rchk(8'hC3, 8'h60);
        rchk(8'h20, 8'h00);
        u_host.wr(7'h4C, 8'h86, 8'h03, ok);
        chk_bit("foreign address ack", 1'b0, ok);
        enable_pin <= 1'b1;
        wst(3'h1);
        repeat (3) @(posedge sys_clk);
        chk_bit("interrupt pin", 1'b1, irq);
        rchk(8'h65, 8'h02);
        rchk(8'h66, 8'h01);
        for (int i = 0; i < 4; i++)
        begin
            lfsr = lfsr_next(lfsr);
            w(8'h44, exp_route(lfsr[1:0]), 8'hF3);
            u_host.rd(DEV, 8'h44, rdv, ok);
            chk_byte("route field", exp_route(lfsr[1:0]), rdv & 8'h0C);
        end
        w(8'h44, 8'h08, 8'hF3);
        chk_byte("still active", 8'h01, {5'h00, state});
        rail_fault <= 1'b1;
        repeat (12) @(posedge sys_clk);
        rail_fault <= 1'b0;
        rchk(8'h66, 8'h03);
        w(8'h86, 8'h03, 8'hFC);
        w(8'h66, 8'h03, 8'h00);
        w(8'h65, 8'h26, 8'h00);
        repeat (4) @(posedge sys_clk);
        chk_bit("interrupt pin", 1'b0, irq);
        chk_byte("kept active", 8'h01, {5'h00, state});
        w(8'h85, 8'h80, 8'h7F);
        w(8'h64, 8'h08, 8'h00);
        w(8'h4F, 8'h00, 8'hF7);
        w(8'h3D, 8'h02, 8'hFD);
        chk_bit("retention hold", 1'b1, hold_gpio);
        w(8'h86, 8'h00, 8'hFC);
        wst(3'h3);
        chk_bit("memory rails", 1'b1, ddr_on);
        rchk(8'h85, 8'h80);
        gpio4_pin <= 1'b0;
        wst(3'h1);
        gpio4_pin <= 1'b1;
        rchk(8'h64, 8'h08);
        w(8'h86, 8'h03, 8'hFC);
        w(8'h64, 8'h08, 8'h00);
        rchk(8'h64, 8'h00);
        w(8'h3D, 8'h00, 8'hFD);
        chk_bit("retention hold", 1'b0, hold_gpio);
        w(8'h85, 8'h00, 8'h7F);
        w(8'hC3, 8'h01, 8'hFE);
        w(8'hC5, 8'h05, 8'hF8);
        w(8'hC2, 8'h01, 8'hFE);
        w(8'h86, 8'h00, 8'hFC);
        wst(3'h2);
        chk_bit("memory rails", 1'b0, ddr_on);
        wst(3'h1);
        w(8'h86, 8'h03, 8'hFC);
        w(8'hC2, 8'h00, 8'hFE);
        w(8'hC5, 8'h00, 8'hFB);
        w(8'hC4, 8'h00, 8'hDF);
        chk_bit("interrupt pin", 1'b0, irq);
        w(8'h85, 8'h01, 8'hFE);
        wst(3'h4);
        chk_bit("processor rails", 1'b0, proc_on);
        rchk(8'h85, 8'h00);
        gpio4_pin <= 1'b0;
        wst(3'h1);
        gpio4_pin <= 1'b1;
        w(8'h64, 8'h08, 8'h00);
        w(8'hC3, 8'h08, 8'hF7);
        enable_pin <= 1'b0;
        wst(3'h5);
        enable_pin <= 1'b1;
        wst(3'h1);
        stop_test();
    end
endmodule
